// File: rtl/nvmac_pkg.sv
// Purpose: shared constants and carrier types of the nvm access block
// Assumes: 8-bit i/o register port from the cpu core
// Notes: offsets are i/o addresses; data-space view adds the data offset
package nvmac_pkg;
  // register offsets (i/o view)
  localparam logic [5:0] NVMAC_OFS_CONTROL = 6'h1c;
  localparam logic [5:0] NVMAC_OFS_DATA = 6'h1d;
  localparam logic [5:0] NVMAC_OFS_ADDR_LOW = 6'h1e;
  localparam logic [5:0] NVMAC_OFS_ADDR_HIGH = 6'h1f;
  localparam logic [6:0] NVMAC_DATA_SPACE_OFS = 7'h20;
  localparam logic [5:0] NVMAC_BIT_ACCESS_TOP = 6'h1f;
  // control field positions
  localparam int NVMAC_BIT_READ = 0;
  localparam int NVMAC_BIT_PROG = 1;
  localparam int NVMAC_BIT_MASTER = 2;
  localparam int NVMAC_BIT_RDY_IE = 3;
  localparam int NVMAC_BIT_MODE_LO = 4;
  localparam int NVMAC_BIT_MODE_HI = 5;
  // reset values
  localparam logic [7:0] NVMAC_DATA_RESET = 8'h00;
  localparam logic [1:0] NVMAC_MODE_RESET = 2'h0;
  // programming modes
  typedef enum logic [1:0] {
    NVMAC_MODE_ATOMIC = 2'b00,
    NVMAC_MODE_ERASE = 2'b01,
    NVMAC_MODE_WRITE = 2'b10,
    NVMAC_MODE_RSVD = 2'b11
  } nvmac_mode_t;
  // timing
  localparam int NVMAC_CLK_HZ = 25000000;
  localparam int NVMAC_ATOMIC_US = 3400;
  localparam int NVMAC_SPLIT_US = 1800;
  localparam int NVMAC_ATOMIC_CYC = NVMAC_ATOMIC_US * (NVMAC_CLK_HZ / 1000000);
  localparam int NVMAC_SPLIT_CYC = NVMAC_SPLIT_US * (NVMAC_CLK_HZ / 1000000);
  localparam logic [2:0] NVMAC_MASTER_CYC = 3'h4;
  localparam logic [2:0] NVMAC_PROG_STALL = 3'h2;
  localparam logic [2:0] NVMAC_READ_STALL = 3'h4;
  // cpu i/o access carrier
  typedef struct packed {
    logic wr;
    logic rd;
    logic bit_op;
    logic [2:0] bit_sel;
    logic [6:0] addr;
    logic [7:0] wdata;
  } nvmac_io_req_t;
  // memory port carrier
  typedef struct packed {
    logic rd;
    logic erase;
    logic wr;
    logic [8:0] addr;
    logic [7:0] wdata;
  } nvmac_mem_req_t;
endpackage : nvmac_pkg

// File: rtl/nvmac_mem.sv
// Purpose: byte-wide data memory array behind the access control
// Assumes: single port, one operation per cycle
// Notes: read data is registered; erase leaves bytes at all ones
module nvmac_mem #(
  parameter int DEPTH = 512
) (
  // clock
  input wire logic clk_in,
  // request
  input wire nvmac_pkg::nvmac_mem_req_t req_in,
  // read data
  output logic [7:0] rdata_out
);
  import nvmac_pkg::*;
  localparam int AW = $clog2(DEPTH);
  logic [7:0] mem [DEPTH];
  always_ff @(posedge clk_in) begin
    if (req_in.erase && req_in.wr) begin
      mem[req_in.addr[AW-1:0]] <= req_in.wdata;
    end else if (req_in.erase) begin
      mem[req_in.addr[AW-1:0]] <= 8'hff;
    end else if (req_in.wr) begin
      // write only can clear bits, never set them
      mem[req_in.addr[AW-1:0]] <= mem[req_in.addr[AW-1:0]] & req_in.wdata;
    end
    if (req_in.rd) begin
      rdata_out <= mem[req_in.addr[AW-1:0]];
    end
  end
endmodule : nvmac_mem

// File: rtl/nvmac_ctrl.sv
// Purpose: i/o register control of the on-chip byte-wide data memory
// Assumes: cpu core drives one i/o access per cycle, honours stall_out
// Notes: one clock; program time counted in system clock cycles
//
// Summary of operation
// - mode 00 atomic, 01 erase, 10 write
// - mode field frozen while programming
// - reset clears mode unless programming
// - ready interrupt level while enabled and idle
// - program flag within four cycles of master
// - program flag ignored without master enable
// - master enable self-clears after four cycles
// - program flag held until time elapses
// - program trigger stalls cpu two cycles
// - read strobe fetches byte immediately
// - read strobe stalls cpu four cycles, two when program triggers in same write
// - reads and address writes refused while busy
// - data register is write source, read sink
// - high address bits 7..1 read zero
// - linear address; small variant bit 7 zero
// - address register undefined after reset
// - control bits 7 and 6 read zero
// - data-space view adds 0x20
// - bit set/clear touches only addressed bit
// - reset lets running programming finish
module nvmac_ctrl #(
  parameter int MEM_BYTES = 512,
  parameter int ATOMIC_CYC = nvmac_pkg::NVMAC_ATOMIC_CYC,
  parameter int SPLIT_CYC = nvmac_pkg::NVMAC_SPLIT_CYC
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // cpu i/o access
  input wire nvmac_pkg::nvmac_io_req_t io_in,
  output logic [7:0] io_rdata_out,
  output logic io_hit_out,
  output logic stall_out,
  // interrupt
  input wire logic global_irq_enable_in,
  output logic ready_irq_out,
  // status
  output logic busy_out
);
  import nvmac_pkg::*;

  localparam int AW = 9;
  localparam logic [8:0] ADDR_MASK = 9'((MEM_BYTES > 256) ? 9'h1ff : (MEM_BYTES > 128) ? 9'h0ff : 9'h07f);
  localparam logic [21:0] ATOMIC_N = 22'(ATOMIC_CYC);
  localparam logic [21:0] SPLIT_N = 22'(SPLIT_CYC);

  typedef struct packed {
    logic rdy_ie;
    logic master;
    logic [2:0] master_cnt;
    logic [7:0] data;
    logic [2:0] stall_cnt;
    logic rd_pend;
    logic [7:0] rdata;
    logic hit;
  } nvmac_state_t;

  // mode and busy timer live apart: the timer, and the mode while programming, ride through reset, so no async clear
  typedef struct packed {
    logic [1:0] mode;
    logic prog;
    logic [21:0] prog_cnt;
  } nvmac_keep_t;

  nvmac_state_t state;
  nvmac_state_t next_state;
  nvmac_keep_t keep;
  nvmac_keep_t next_keep;
  // power-up only: gives the busy timer a known start
  logic prog_init = 1'b1;
  logic [AW-1:0] addr;
  logic [AW-1:0] next_addr;
  logic [7:0] mem_rdata;
  nvmac_mem_req_t mem_req;

  // decoded access
  logic [5:0] io_ofs;
  logic in_range;
  logic [7:0] ctrl_rd;
  logic [7:0] cur;
  logic [7:0] wval;
  logic trig_prog;
  logic trig_read;

  always_comb begin
    if (io_in.addr >= NVMAC_DATA_SPACE_OFS) begin
      io_ofs = 6'(io_in.addr - NVMAC_DATA_SPACE_OFS);
      // data view covers i/o 0x00..0x3f only; above 0x5f is not i/o
      in_range = !(io_in.addr[6] && io_in.addr[5]);
    end else begin
      io_ofs = io_in.addr[5:0];
      in_range = 1'b1;
    end
  end

  // control readback with zero top bits
  assign ctrl_rd = {2'b00, keep.mode, state.rdy_ie, state.master, keep.prog, 1'b0};

  always_comb begin
    unique case (io_ofs)
      NVMAC_OFS_CONTROL: cur = ctrl_rd;
      NVMAC_OFS_DATA: cur = state.data;
      NVMAC_OFS_ADDR_LOW: cur = 8'(addr & ADDR_MASK);
      NVMAC_OFS_ADDR_HIGH: cur = {7'h00, addr[8] & ADDR_MASK[8]};
      default: cur = 8'h00;
    endcase
  end

  // bit op merges one bit into current value
  always_comb begin
    wval = io_in.wdata;
    if (io_in.bit_op && io_ofs <= NVMAC_BIT_ACCESS_TOP) begin
      wval = cur;
      wval[io_in.bit_sel] = io_in.wdata[0];
    end
  end

  logic wr_ctrl;
  logic wr_data;
  logic wr_al;
  logic wr_ah;
  // one write strobe per register; other offsets take nothing
  always_comb begin
    wr_ctrl = 1'b0;
    wr_data = 1'b0;
    wr_al = 1'b0;
    wr_ah = 1'b0;
    if (io_in.wr && in_range) begin
      unique case (io_ofs)
        NVMAC_OFS_CONTROL: wr_ctrl = 1'b1;
        NVMAC_OFS_DATA: wr_data = 1'b1;
        NVMAC_OFS_ADDR_LOW: wr_al = 1'b1;
        NVMAC_OFS_ADDR_HIGH: wr_ah = 1'b1;
        default: wr_ctrl = 1'b0;
      endcase
    end
  end

  // program trigger only inside the master window; read trigger needs only idle
  assign trig_prog = wr_ctrl && wval[NVMAC_BIT_PROG] && state.master && !keep.prog;
  assign trig_read = wr_ctrl && wval[NVMAC_BIT_READ] && !keep.prog;

  always_comb begin
    next_state = state;
    // only the four registers of this block answer a read
    next_state.hit = io_in.rd && in_range && (io_ofs[5:2] == NVMAC_OFS_CONTROL[5:2]);
    if (io_in.rd && in_range) begin
      next_state.rdata = cur;
    end
    if (state.stall_cnt != 3'h0) begin
      next_state.stall_cnt = 3'(state.stall_cnt - 3'h1);
    end
    if (state.master) begin
      if (state.master_cnt == 3'h1) begin
        next_state.master = 1'b0;
        next_state.master_cnt = 3'h0;
      end else begin
        next_state.master_cnt = 3'(state.master_cnt - 3'h1);
      end
    end
    if (wr_ctrl) begin
      next_state.rdy_ie = wval[NVMAC_BIT_RDY_IE];
      if (wval[NVMAC_BIT_MASTER] && !state.master) begin
        next_state.master = 1'b1;
        next_state.master_cnt = NVMAC_MASTER_CYC;
      end
    end
    if (wr_data) begin
      next_state.data = wval;
    end
    // read result lands in data register
    if (state.rd_pend) begin
      next_state.data = mem_rdata;
      next_state.rd_pend = 1'b0;
    end
    if (trig_read) begin
      next_state.rd_pend = 1'b1;
      next_state.stall_cnt = NVMAC_READ_STALL;
    end
    if (trig_prog) begin
      next_state.master = 1'b0;
      next_state.master_cnt = 3'h0;
      next_state.stall_cnt = NVMAC_PROG_STALL;
    end
  end

  // busy timer and mode; while reset is low only the timer runs on
  always_comb begin
    next_keep = keep;
    if (keep.prog) begin
      if (keep.prog_cnt <= 22'h1) begin
        next_keep.prog = 1'b0;
        next_keep.prog_cnt = 22'h0;
      end else begin
        next_keep.prog_cnt = 22'(keep.prog_cnt - 22'h1);
      end
    end
    if (!resetn_in) begin
      // mode back to 00 unless still programming
      if (!keep.prog) begin
        next_keep.mode = NVMAC_MODE_RESET;
      end
    end else begin
      if (wr_ctrl && !keep.prog) begin
        next_keep.mode = wval[NVMAC_BIT_MODE_HI:NVMAC_BIT_MODE_LO];
      end
      if (trig_prog) begin
        next_keep.prog = 1'b1;
        // time per mode; reserved code holds busy one cycle only
        unique case (nvmac_mode_t'(keep.mode))
          NVMAC_MODE_ATOMIC: next_keep.prog_cnt = ATOMIC_N;
          NVMAC_MODE_ERASE: next_keep.prog_cnt = SPLIT_N;
          NVMAC_MODE_WRITE: next_keep.prog_cnt = SPLIT_N;
          NVMAC_MODE_RSVD: next_keep.prog_cnt = 22'h1;
        endcase
      end
    end
  end

  // memory request; commit happens at trigger, timer models busy time
  always_comb begin
    mem_req = '0;
    mem_req.addr = addr & ADDR_MASK;
    mem_req.wdata = state.data;
    mem_req.rd = trig_read;
    if (trig_prog) begin
      unique case (nvmac_mode_t'(keep.mode))
        NVMAC_MODE_ATOMIC: begin
          mem_req.erase = 1'b1;
          mem_req.wr = 1'b1;
        end
        NVMAC_MODE_ERASE: mem_req.erase = 1'b1;
        NVMAC_MODE_WRITE: mem_req.wr = 1'b1;
        NVMAC_MODE_RSVD: mem_req.wr = 1'b0;
      endcase
    end
  end

  // address has no reset; frozen while busy
  always_comb begin
    next_addr = addr;
    if (!keep.prog) begin
      if (wr_al) begin
        next_addr[7:0] = wval;
      end
      if (wr_ah) begin
        next_addr[8] = wval[0];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    addr <= next_addr;
  end

  // interrupt enable, master bit, data and halt clear at once on reset; mode is not in this block
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state.rdy_ie <= 1'b0;
      state.master <= 1'b0;
      state.master_cnt <= 3'h0;
      state.data <= NVMAC_DATA_RESET;
      state.stall_cnt <= 3'h0;
      state.rd_pend <= 1'b0;
      state.rdata <= 8'h00;
      state.hit <= 1'b0;
    end else begin
      state.rdy_ie <= next_state.rdy_ie;
      state.master <= next_state.master;
      state.master_cnt <= next_state.master_cnt;
      state.data <= next_state.data;
      state.stall_cnt <= next_state.stall_cnt;
      state.rd_pend <= next_state.rd_pend;
      state.rdata <= next_state.rdata;
      state.hit <= next_state.hit;
    end
  end

  // running program finishes across reset
  // no async clear here: an aborted program would leave the byte half-written
  always_ff @(posedge clk_in) begin
    if (prog_init) begin
      keep.mode <= NVMAC_MODE_RESET;
      keep.prog <= 1'b0;
      keep.prog_cnt <= 22'h0;
    end else begin
      keep <= next_keep;
    end
  end

  // power-up: busy timer starts cleared at first edge
  always_ff @(posedge clk_in) begin
    prog_init <= 1'b0;
  end

  nvmac_mem #(
    .DEPTH(MEM_BYTES)
  ) u_mem (
    .clk_in(clk_in),
    .req_in(mem_req),
    .rdata_out(mem_rdata)
  );

  assign io_rdata_out = state.rdata;
  assign io_hit_out = state.hit;
  assign stall_out = (state.stall_cnt != 3'h0);
  assign busy_out = keep.prog;
  assign ready_irq_out = state.rdy_ie && global_irq_enable_in && !keep.prog;
endmodule : nvmac_ctrl

// File: dv/nvmac_ctrl_monitor.sv
// Purpose: port checks for nvmac_ctrl
// Assumes: one clock, async active-low reset
// Notes: busy length kept in a helper counter
module nvmac_ctrl_monitor #(
  parameter int MEM_BYTES = 512,
  parameter int ATOMIC_CYC = nvmac_pkg::NVMAC_ATOMIC_CYC,
  parameter int SPLIT_CYC = nvmac_pkg::NVMAC_SPLIT_CYC
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // cpu side
  input wire nvmac_pkg::nvmac_io_req_t io_in,
  input wire logic [7:0] io_rdata_out,
  input wire logic io_hit_out,
  input wire logic stall_out,
  // status
  input wire logic global_irq_enable_in,
  input wire logic ready_irq_out,
  input wire logic busy_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import nvmac_pkg::*;
  int busy_len;
  logic ctrl_wr;
  logic rd_trig;
  assign ctrl_wr = io_in.wr && io_in.addr inside {7'h1c, 7'h3c};
  assign rd_trig = ctrl_wr && io_in.wdata[0] && (!io_in.bit_op || io_in.bit_sel == 3'h0);
  // no reset: the program timer also runs through reset
  always_ff @(posedge clk_in) begin
    busy_len <= busy_out ? busy_len + 1 : 0;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  sequence prog_halt_s;
    stall_out [*2] ##1 !stall_out;
  endsequence
  sequence read_halt_s;
    stall_out [*4] ##1 !stall_out;
  endsequence
  a_prog_halt_two:
    assert property ($rose(busy_out) |-> prog_halt_s) else $error("program halt length wrong");
  a_read_halt_four:
    assert property (rd_trig && !busy_out |=> read_halt_s) else $error("read halt length wrong");
  a_read_refused_busy:
    assert property (rd_trig && busy_out && !stall_out |=> !stall_out) else $error("read taken while busy");
  a_busy_time_mode:
    assert property ($fell(busy_out) |-> busy_len inside {ATOMIC_CYC, SPLIT_CYC, 1}) else $error("busy length wrong");
  a_trigger_needs_write:
    assert property ($rose(busy_out) |-> $past(ctrl_wr)) else $error("busy without control write");
  a_irq_when_idle:
    assert property (ready_irq_out |-> global_irq_enable_in && !busy_out) else $error("ready irq while busy");
  a_hit_after_read:
    assert property (io_hit_out == $past(io_in.rd && !io_in.addr[6] && io_in.addr[4:2] == 3'h7)) else $error("hit wrong");
  a_ctrl_top_zero:
    assert property (io_hit_out && $past(io_in.addr[1:0]) == 2'h0 |-> io_rdata_out[7:6] == 2'h0) else $error("top bits set");
endmodule : nvmac_ctrl_monitor
bind nvmac_ctrl nvmac_ctrl_monitor #(.MEM_BYTES(MEM_BYTES), .ATOMIC_CYC(ATOMIC_CYC), .SPLIT_CYC(SPLIT_CYC))
  i_nvmac_ctrl_monitor (.clk_in(clk_in), .resetn_in(resetn_in), .io_in(io_in), .io_rdata_out(io_rdata_out),
  .io_hit_out(io_hit_out), .stall_out(stall_out), .global_irq_enable_in(global_irq_enable_in),
  .ready_irq_out(ready_irq_out), .busy_out(busy_out));

// File: dv/nvmac_cpu_model.sv
// Purpose: cpu core model issuing i/o accesses
// Assumes: requests move 1 ns after the rising edge
// Notes: waits out any halt; idle bus is all zero
module nvmac_cpu_model (
  // clock and halt
  input wire logic clk_in,
  input wire logic stall_in,
  // i/o port
  input wire logic [7:0] rdata_in,
  output nvmac_pkg::nvmac_io_req_t io_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import nvmac_pkg::*;
  initial io_out = '0;
  // idle edge after each access keeps one assignment per time step
  task automatic access(input logic w, input logic b, input logic [2:0] s, input logic [6:0] a,
                        input logic [7:0] d, output logic [7:0] q);
    while (stall_in !== 1'b0) begin
      @(posedge clk_in);
      #1;
    end
    io_out = '{wr: w, rd: !w, bit_op: b, bit_sel: s, addr: a, wdata: d};
    @(posedge clk_in);
    #1;
    io_out = '0;
    q = rdata_in;
    @(posedge clk_in);
    #1;
  endtask : access
  task automatic poll_idle(output logic ok);
    logic [7:0] c;
    ok = 1'b0;
    for (int i = 0; i < 100 && !ok; i++) begin
      access(1'b0, 1'b0, 3'h0, 7'h1c, 8'h00, c);
      ok = c[1] === 1'b0;
    end
  endtask : poll_idle
endmodule : nvmac_cpu_model

// File: dv/nvmac_ctrl_tb.sv
// Purpose: self-checking bench for nvmac_ctrl
// Assumes: program times shortened to 40 and 20 cycles
// Notes: memory checked back through the read strobe
module nvmac_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import nvmac_pkg::*;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic irq_en = 1'b0;
  nvmac_io_req_t io;
  logic [7:0] rdata;
  logic [7:0] q;
  logic hit, stall, irq, busy, ok;
  int mismatches = 0;
  int check_count = 0;
  logic [1:0] modes [4] = '{2'h1, 2'h2, 2'h2, 2'h3};
  logic [7:0] datas [4] = '{8'h00, 8'h3c, 8'h0f, 8'h00};
  logic [7:0] exps [4] = '{8'hff, 8'h3c, 8'h0c, 8'h0c};
  always #20 clk_in = ~clk_in;
  nvmac_ctrl #(.MEM_BYTES(512), .ATOMIC_CYC(40), .SPLIT_CYC(20)) i_nvmac_ctrl (.clk_in(clk_in),
    .resetn_in(resetn_in), .io_in(io), .io_rdata_out(rdata), .io_hit_out(hit), .stall_out(stall),
    .global_irq_enable_in(irq_en), .ready_irq_out(irq), .busy_out(busy));
  nvmac_cpu_model i_nvmac_cpu_model (.clk_in(clk_in), .stall_in(stall), .rdata_in(rdata), .io_out(io));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_nvmac_cpu_model.access(1'b1, 1'b0, 3'h0, a, d, q);
  endtask : wr
  task automatic bs(input logic [2:0] s, input logic v);
    i_nvmac_cpu_model.access(1'b1, 1'b1, s, 7'h1c, {7'h0, v}, q);
  endtask : bs
  task automatic rd(input logic [6:0] a);
    i_nvmac_cpu_model.access(1'b0, 1'b0, 3'h0, a, 8'h00, q);
  endtask : rd
  task automatic fetch(input logic [7:0] e);
    bs(3'h0, 1'b1);
    rd(7'h3d);
    chk(q, e);
  endtask : fetch
  task automatic pulse_reset();
    resetn_in = 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    resetn_in = 1'b1;
  endtask : pulse_reset
  initial begin
    repeat (6) @(posedge clk_in);
    #1;
    resetn_in = 1'b1;
    rd(7'h1d);
    chk(q, 8'h00);
    rd(7'h1c);
    chk(q, 8'h00);
    $display("test reset values done");
    wr(7'h1f, 8'h01);
    wr(7'h3e, 8'h5a);
    wr(7'h1d, 8'ha5);
    wr(7'h1c, 8'h04);
    bs(3'h1, 1'b1);
    chk({7'h0, busy}, 8'h01);
    bs(3'h5, 1'b1);
    wr(7'h1e, 8'h00);
    bs(3'h0, 1'b1);
    i_nvmac_cpu_model.poll_idle(ok);
    chk({7'h0, ok}, 8'h01);
    rd(7'h1c);
    chk(q, 8'h00);
    wr(7'h1d, 8'h00);
    fetch(8'ha5);
    rd(7'h1f);
    chk(q, 8'h01);
    $display("test atomic and busy refusals done");
    for (int i = 0; i < 4; i++) begin
      wr(7'h1d, datas[i]);
      wr(7'h1c, {2'h0, modes[i], 4'h4});
      bs(3'h1, 1'b1);
      i_nvmac_cpu_model.poll_idle(ok);
      chk({7'h0, ok}, 8'h01);
      fetch(exps[i]);
    end
    $display("test modes done");
    wr(7'h1c, 8'h04);
    rd(7'h1c);
    chk(q, 8'h04);
    repeat (2) @(posedge clk_in);
    #1;
    bs(3'h1, 1'b1);
    chk({7'h0, busy}, 8'h00);
    $display("test master window done");
    irq_en = 1'b1;
    bs(3'h3, 1'b1);
    chk({7'h0, irq}, 8'h01);
    rd(7'h1c);
    chk(q, 8'h08);
    bs(3'h3, 1'b0);
    chk({7'h0, irq}, 8'h00);
    $display("test ready irq done");
    wr(7'h1c, 8'h14);
    bs(3'h1, 1'b1);
    pulse_reset();
    chk({7'h0, busy}, 8'h01);
    i_nvmac_cpu_model.poll_idle(ok);
    chk({7'h0, ok}, 8'h01);
    rd(7'h1c);
    chk(q, 8'h10);
    pulse_reset();
    rd(7'h1c);
    chk(q, 8'h00);
    $display("test reset while busy done");
    wrap_up();
  end
  // tests need well under 1500 cycles
  initial begin
    #120000;
    mismatches++;
    wrap_up();
  end
endmodule : nvmac_ctrl_tb
